/* common/rag_consts.svh */
`ifndef RAG_CONSTS_SVH
`define RAG_CONSTS_SVH
`define RAG_WORD_W 10
`define RAG_PC_W 14
`define RAG_RAM_W 10
`define RAG_SCRATCH_BASE 10'h040
`define RAG_PAGE_LSB 8
`define RAG_ZP_W 6
`define RAG_ACC_BIT 8
`define RAG_PORT_BIT 9
`define RAG_PC_RST 14'h0000
`define RAG_NIB_RST 4'h0
`define RAG_PC_ONE 14'h0001
`endif

/* common/rag_pkg.sv */
package rag_pkg;
  typedef enum logic [3:0] {
    RAG_OP_NONE,
    RAG_OP_INDIRECT,
    RAG_OP_DIRECT,
    RAG_OP_LOAD_SCRATCH,
    RAG_OP_SWAP_SCRATCH,
    RAG_OP_LONG_JUMP,
    RAG_OP_LONG_BRANCH,
    RAG_OP_LONG_CALL,
    RAG_OP_PAGE_BRANCH,
    RAG_OP_ZERO_CALL,
    RAG_OP_TABLE_BRANCH,
    RAG_OP_TABLE_FETCH
  } rag_op_t;
  typedef enum logic [1:0] {
    RAG_ST_FIRST,
    RAG_ST_SECOND,
    RAG_ST_FETCH
  } rag_state_t;
endpackage

/* rtl/rag_addr_gen.sv */
// Function
// - every instruction and operand word is handled as ten bits
// - indirect RAM address joins high, mid and low index registers
// - direct RAM address is the whole ten-bit second word
// - scratch digits sit at 040 to 04F, reached by load and swap ops
// - long jump, branch and call load all fourteen pc bits
// - rom is 64 pages of 256 words; low eight bits select the word
// - page branch loads low eight pc bits, takes page bits from the incremented pc
// - page branch at page end lands in next page via incremented pc
// - zero-page call loads pc bits 5..0 and clears 13..6
// - table branch target from immediate, accumulator and aux nibble
// - table fetch with bit 8 set loads accumulator and aux nibble
// - table fetch with bit 9 set loads both port output registers
// - both bits set update all four registers together
// - table fetch leaves pc at its sequential advance only
`timescale 1ns/1ps
`include "rag_consts.svh"
module rag_addr_gen
  import rag_pkg::*;
#(
  parameter int PC_W = `RAG_PC_W
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [`RAG_WORD_W-1:0] instr_word,
  input wire rag_op_t instr_op,
  input wire logic [3:0] addr_high_reg,
  input wire logic [3:0] addr_mid_reg,
  input wire logic [1:0] addr_low_reg,
  input wire logic [3:0] acc_in,
  input wire logic [3:0] aux_in,
  input wire logic rom_data_valid,
  input wire logic [`RAG_WORD_W-1:0] rom_data,
  output logic [PC_W-1:0] pc,
  output logic [PC_W-1:0] rom_addr,
  output logic rom_rd,
  output logic [`RAG_RAM_W-1:0] ram_addr,
  output logic ram_addr_valid,
  output logic busy,
  output logic acc_we,
  output logic [3:0] acc_out,
  output logic [3:0] aux_out,
  output logic [3:0] port_one_out_reg,
  output logic [3:0] port_two_out_reg
);
  // table and long targets are laid out for exactly fourteen bits
  if (PC_W != `RAG_PC_W) begin : g_bad_pc_w
    $error("pc width must be 14");
  end

  function automatic logic [PC_W-1:0] table_addr(input logic [3:0] imm,
      input logic [3:0] aux, input logic [3:0] acc);
    table_addr = {{(PC_W-12){1'b0}}, imm, aux, acc};
  endfunction

  rag_state_t state;
  rag_op_t held_op;
  wire logic take = instr_valid && (state == RAG_ST_FIRST);
  wire logic take2 = instr_valid && (state == RAG_ST_SECOND);
  wire logic [PC_W-1:0] pc_inc = pc + `RAG_PC_ONE;
  wire logic two_word = (instr_op == RAG_OP_DIRECT) || (instr_op == RAG_OP_LONG_JUMP)
    || (instr_op == RAG_OP_LONG_BRANCH) || (instr_op == RAG_OP_LONG_CALL);
  wire logic [PC_W-1:0] page_target =
    {pc_inc[PC_W-1:`RAG_PAGE_LSB], instr_word[7:0]};
  wire logic [PC_W-1:0] zp_target =
    {{(PC_W-`RAG_ZP_W){1'b0}}, instr_word[`RAG_ZP_W-1:0]};
  wire logic [PC_W-1:0] tbl = table_addr(instr_word[3:0], aux_in, acc_in);
  wire logic [`RAG_RAM_W-1:0] ind_addr =
    {addr_high_reg, addr_mid_reg, addr_low_reg};
  wire logic [`RAG_RAM_W-1:0] scr_addr =
    `RAG_SCRATCH_BASE | {6'h00, instr_word[3:0]};
  wire logic fetch_acc = rom_data[`RAG_ACC_BIT];
  wire logic fetch_port = rom_data[`RAG_PORT_BIT];
  logic [3:0] long_hi;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= RAG_ST_FIRST;
      held_op <= RAG_OP_NONE;
      long_hi <= `RAG_NIB_RST;
      pc <= `RAG_PC_RST;
      rom_addr <= `RAG_PC_RST;
      rom_rd <= 1'b0;
      ram_addr <= '0;
      ram_addr_valid <= 1'b0;
      busy <= 1'b0;
      acc_we <= 1'b0;
      acc_out <= `RAG_NIB_RST;
      aux_out <= `RAG_NIB_RST;
      port_one_out_reg <= `RAG_NIB_RST;
      port_two_out_reg <= `RAG_NIB_RST;
    end else begin
      ram_addr_valid <= 1'b0;
      rom_rd <= 1'b0;
      acc_we <= 1'b0;
      unique case (state)
        RAG_ST_FIRST: begin
          if (take) begin
            pc <= pc_inc;
            held_op <= instr_op;
            long_hi <= instr_word[3:0];
            unique case (instr_op)
              RAG_OP_INDIRECT: begin
                ram_addr <= ind_addr;
                ram_addr_valid <= 1'b1;
              end
              RAG_OP_LOAD_SCRATCH, RAG_OP_SWAP_SCRATCH: begin
                ram_addr <= scr_addr;
                ram_addr_valid <= 1'b1;
              end
              RAG_OP_PAGE_BRANCH: pc <= page_target;
              RAG_OP_ZERO_CALL: pc <= zp_target;
              RAG_OP_TABLE_BRANCH: pc <= tbl;
              RAG_OP_TABLE_FETCH: begin
                rom_addr <= tbl;
                rom_rd <= 1'b1;
                busy <= 1'b1;
                state <= RAG_ST_FETCH;
              end
              default: begin
                if (two_word) begin
                  busy <= 1'b1;
                  state <= RAG_ST_SECOND;
                end
              end
            endcase
          end
        end
        RAG_ST_SECOND: begin
          if (take2) begin
            busy <= 1'b0;
            state <= RAG_ST_FIRST;
            if (held_op == RAG_OP_DIRECT) begin
              pc <= pc_inc;
              ram_addr <= instr_word;
              ram_addr_valid <= 1'b1;
            end else begin
              pc <= {long_hi, instr_word};
            end
          end
        end
        RAG_ST_FETCH: begin
          // pc untouched while the table word is read
          if (rom_data_valid) begin
            busy <= 1'b0;
            state <= RAG_ST_FIRST;
            if (fetch_acc) begin
              acc_we <= 1'b1;
              acc_out <= rom_data[3:0];
              aux_out <= rom_data[7:4];
            end
            if (fetch_port) begin
              port_one_out_reg <= rom_data[3:0];
              port_two_out_reg <= rom_data[7:4];
            end
          end
        end
      endcase
    end
  end

  a_long_jump_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take2 && held_op != RAG_OP_DIRECT) |=> pc == $past({long_hi, instr_word}))
    else $error("long jump target wrong");
  a_page_branch_pc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && instr_op == RAG_OP_PAGE_BRANCH) |=>
    pc[PC_W-1:8] == $past(pc_inc[PC_W-1:8]) && pc[7:0] == $past(instr_word[7:0]))
    else $error("page branch target wrong");
  a_zero_call_pc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && instr_op == RAG_OP_ZERO_CALL) |=>
    pc[PC_W-1:6] == '0 && pc[5:0] == $past(instr_word[5:0]))
    else $error("zero page call target wrong");
  a_table_branch_pc: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && instr_op == RAG_OP_TABLE_BRANCH) |=>
    pc == {2'b00, $past(instr_word[3:0]), $past(aux_in), $past(acc_in)})
    else $error("table branch target wrong");
  a_fetch_addr_form: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && instr_op == RAG_OP_TABLE_FETCH) |=> rom_rd && busy &&
    rom_addr == {2'b00, $past(instr_word[3:0]), $past(aux_in), $past(acc_in)})
    else $error("table fetch address wrong");
  a_fetch_pc_seq: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && instr_op == RAG_OP_TABLE_FETCH) |=> pc == $past(pc_inc))
    else $error("table fetch moved pc");
  a_fetch_pc_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == RAG_ST_FETCH) |=> $stable(pc))
    else $error("pc moved during table fetch");
  a_fetch_port_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == RAG_ST_FETCH && rom_data_valid && fetch_port) |=>
    port_two_out_reg == $past(rom_data[7:4]) &&
    port_one_out_reg == $past(rom_data[3:0]))
    else $error("port registers not loaded");
  a_port_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == RAG_ST_FETCH && rom_data_valid && !fetch_port) |=>
    $stable(port_one_out_reg) && $stable(port_two_out_reg))
    else $error("port registers changed without bit 9");
  a_fetch_acc_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == RAG_ST_FETCH && rom_data_valid) |=> acc_we == $past(fetch_acc))
    else $error("accumulator write mismatch");
  a_fetch_acc_data: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == RAG_ST_FETCH && rom_data_valid && fetch_acc) |=>
    aux_out == $past(rom_data[7:4]) && acc_out == $past(rom_data[3:0]))
    else $error("accumulator data wrong");
  a_both_bits_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == RAG_ST_FETCH && rom_data_valid && fetch_acc && fetch_port) |=>
    acc_we && {aux_out, acc_out} == $past(rom_data[7:0]) &&
    {port_two_out_reg, port_one_out_reg} == $past(rom_data[7:0]))
    else $error("combined table load wrong");
  a_indirect_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && instr_op == RAG_OP_INDIRECT) |=>
    ram_addr_valid && ram_addr == $past(ind_addr))
    else $error("indirect address wrong");
  a_direct_addr: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take2 && held_op == RAG_OP_DIRECT) |=> ram_addr_valid && ram_addr == $past(instr_word))
    else $error("direct address wrong");
  a_scratch_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && (instr_op == RAG_OP_SWAP_SCRATCH || instr_op == RAG_OP_LOAD_SCRATCH)) |=>
    ram_addr_valid && ram_addr[9:4] == 6'h04 && ram_addr[3:0] == $past(instr_word[3:0]))
    else $error("scratch address out of range");
  a_seq_advance: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (take && instr_op == RAG_OP_INDIRECT) |=> pc == $past(pc_inc))
    else $error("pc did not advance");
endmodule

/* sim/rag_tb.sv */
`timescale 1ns/1ps
`include "rag_consts.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  import rag_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0;
  logic [9:0] instr_word = 10'h000;
  rag_op_t instr_op = RAG_OP_NONE;
  logic [3:0] addr_high_reg = 4'h0;
  logic [3:0] addr_mid_reg = 4'h0;
  logic [1:0] addr_low_reg = 2'h0;
  logic [3:0] acc_in = 4'h0;
  logic [3:0] aux_in = 4'h0;
  logic rom_data_valid = 1'b0;
  logic [9:0] rom_data = 10'h000;
  logic [13:0] pc, rom_addr, exp_pc, nxt;
  logic [9:0] ram_addr;
  logic rom_rd, ram_addr_valid, busy, acc_we;
  logic [3:0] acc_out, aux_out, port_one_out_reg, port_two_out_reg, imm, p1, p2, ea, eb;
  logic [31:0] r, s;
  rag_op_t long_ops [3] = '{RAG_OP_LONG_JUMP, RAG_OP_LONG_BRANCH, RAG_OP_LONG_CALL};
  int n_mismatch = 0;
  int cmp_count = 0;
  int seed = 1131;
  rag_addr_gen dut (.sys_clk, .sys_rst, .instr_valid, .instr_word, .instr_op, .addr_high_reg,
    .addr_mid_reg, .addr_low_reg, .acc_in, .aux_in, .rom_data_valid, .rom_data, .pc, .rom_addr,
    .rom_rd, .ram_addr, .ram_addr_valid, .busy, .acc_we, .acc_out, .aux_out,
    .port_one_out_reg, .port_two_out_reg);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one instruction word taken at the next rising edge, outputs settled after it
  task automatic issue(input rag_op_t op, input logic [9:0] w);
    @(negedge sys_clk);
    instr_valid = 1'b1;
    instr_op = op;
    instr_word = w;
    @(posedge sys_clk);
    #1;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    p1 = 4'h0;
    p2 = 4'h0;
    ea = 4'h0;
    eb = 4'h0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    `CHK(pc, `RAG_PC_RST)
    `CHK({busy, rom_rd, ram_addr_valid, acc_we}, 4'h0)
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      s = $random(seed);
      if (i[0]) r[7:0] = 8'hFF; // last word of a page
      issue(long_ops[i % 3], {6'h00, r[13:10]});
      issue(RAG_OP_NONE, r[9:0]);
      exp_pc = r[13:0];
      `CHK(pc, exp_pc)
      nxt = exp_pc + 14'h0001;
      issue(RAG_OP_PAGE_BRANCH, {2'b00, r[21:14]});
      exp_pc = {nxt[13:8], r[21:14]};
      `CHK(pc, exp_pc)
      issue(RAG_OP_ZERO_CALL, {4'h0, r[27:22]});
      exp_pc = {8'h00, r[27:22]};
      `CHK(pc, exp_pc)
      addr_high_reg = s[9:6];
      addr_mid_reg = s[5:2];
      addr_low_reg = s[1:0];
      issue(RAG_OP_INDIRECT, s[19:10]);
      exp_pc = exp_pc + 14'h0001;
      `CHK(ram_addr, s[9:0])
      `CHK(ram_addr_valid, 1'b1)
      `CHK(pc, exp_pc)
      issue(RAG_OP_DIRECT, s[29:20]);
      issue(RAG_OP_NONE, s[19:10]);
      exp_pc = exp_pc + 14'h0002;
      `CHK(ram_addr, s[19:10])
      `CHK(ram_addr_valid, 1'b1)
      `CHK(pc, exp_pc)
      issue(i[0] ? RAG_OP_LOAD_SCRATCH : RAG_OP_SWAP_SCRATCH, {6'h00, s[23:20]});
      `CHK(ram_addr, 10'h040 + {6'h00, s[23:20]})
      acc_in = s[27:24];
      aux_in = s[31:28];
      imm = r[31:28];
      issue(RAG_OP_TABLE_BRANCH, {6'h00, imm});
      exp_pc = {2'b00, imm, aux_in, acc_in};
      `CHK(pc, exp_pc)
      issue(RAG_OP_TABLE_FETCH, {6'h00, imm});
      exp_pc = exp_pc + 14'h0001;
      `CHK(rom_addr, {2'b00, imm, aux_in, acc_in})
      `CHK({rom_rd, busy}, 2'b11)
      @(negedge sys_clk);
      instr_valid = 1'b0;
      rom_data_valid = 1'b1;
      rom_data = {i[1:0], s[7:0]};
      if (i[1]) p1 = s[3:0];
      if (i[1]) p2 = s[7:4];
      if (i[0]) ea = s[3:0];
      if (i[0]) eb = s[7:4];
      @(posedge sys_clk);
      #1;
      `CHK(acc_we, i[0])
      `CHK({aux_out, acc_out}, {eb, ea})
      `CHK({rom_rd, busy}, 2'b00)
      `CHK({port_two_out_reg, port_one_out_reg}, {p2, p1})
      `CHK(pc, exp_pc)
      @(negedge sys_clk);
      rom_data_valid = 1'b0;
    end
    wrap_up();
  end
endmodule
